// >>> pkg/difs_pkg.sv
package difs_pkg;

   // ==========================================================
   // Sizes
   // ==========================================================
   localparam int NUM_INPUTS   = 4;
   localparam int FUNC_W       = 3;
   localparam int REF_W        = 16;
   localparam int ADDR_W       = 4;
   localparam int DATA_W       = 32;

   // ==========================================================
   // Function settings of one input line
   // ==========================================================
   typedef enum logic [FUNC_W-1:0] {
      FUNC_EDGE_TOGGLE        = 3'h0,
      FUNC_LEVEL_SELECT_AUTO  = 3'h1,
      FUNC_CENTRE             = 3'h2,
      FUNC_DEC_LEFT           = 3'h3,
      FUNC_INC_RIGHT          = 3'h4,
      FUNC_LOCK               = 3'h5,
      FUNC_REFERENCE_CLEAR    = 3'h6,
      FUNC_DISABLED           = 3'h7
   } difs_func_t;

   // Motor drive command
   typedef enum logic [2:0] {
      DRV_IDLE   = 3'h0,
      DRV_LEFT   = 3'h1,
      DRV_RIGHT  = 3'h2,
      DRV_CENTRE = 3'h3,
      DRV_STOP   = 3'h4
   } difs_drive_t;

   // Per-line rise pulse and level produced by the edge detector
   typedef struct packed {
      logic rise;
      logic level;
   } difs_line_t;

   // ==========================================================
   // Register map (word index = byte address / 4)
   // ==========================================================
   localparam logic [ADDR_W-1:0] ADDR_FUNC_SEL  = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_STATUS    = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_REFERENCE = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_INPUTS    = 4'h3;

   // Function-select field of input n sits at bits [FUNC_W*n +: FUNC_W]
   localparam logic [FUNC_W*NUM_INPUTS-1:0] FUNC_SEL_RESET = {
      FUNC_INC_RIGHT, FUNC_DEC_LEFT, FUNC_CENTRE, FUNC_EDGE_TOGGLE};

   // Status word fields
   localparam int STAT_AUTO_BIT  = 0;
   localparam int STAT_DRIVE_LSB = 4;

   localparam logic [REF_W-1:0] REF_RESET = 16'h0000;
   localparam logic [REF_W-1:0] REF_STEP  = 16'h0001;

endpackage

// >>> core/difs_sync.sv
`timescale 1ns/1ps
module difs_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;

   // ==========================================================
   // Two-stage synchroniser; first stage feeds only the second
   // ==========================================================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff  <= '0;
         sync_out <= '0;
      end else begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule // difs_sync

// >>> core/difs_edge.sv
`timescale 1ns/1ps
module difs_edge #(
   parameter int WIDTH = 4
) (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic [WIDTH-1:0]                level_in,
   output      difs_pkg::difs_line_t [WIDTH-1:0] line_out
);
   import difs_pkg::*;

   logic [WIDTH-1:0] prev_ff;

   // ==========================================================
   // Rising-edge detect on already synchronised levels
   // ==========================================================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_ff <= '0;
      end else begin
         prev_ff <= level_in;
      end
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_line
      assign line_out[i].level = level_in[i];
      assign line_out[i].rise  = level_in[i] & ~prev_ff[i];
   end
endmodule // difs_edge

// >>> core/difs_top.sv
`timescale 1ns/1ps
module difs_top #(
   parameter int NUM_IN = difs_pkg::NUM_INPUTS
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic [NUM_IN-1:0]           dig_in,
   input  wire logic [difs_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [difs_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output      logic [difs_pkg::DATA_W-1:0] reg_rdata_ff,
   output      logic                        auto_mode_ff,
   output      difs_pkg::difs_drive_t       drive_cmd_ff,
   output      logic [difs_pkg::REF_W-1:0]  reference_ff,
   output      logic                        centre_start_ff
);
   import difs_pkg::*;

   localparam int SEL_W = FUNC_W * NUM_IN;

   logic [NUM_IN-1:0]       sync_lvl;
   difs_line_t [NUM_IN-1:0] line;
   logic [SEL_W-1:0]        func_sel_ff;

   // ==========================================================
   // Input conditioning
   // ==========================================================
   difs_sync #(.WIDTH(NUM_IN)) u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in (dig_in),
      .sync_out (sync_lvl)
   );

   difs_edge #(.WIDTH(NUM_IN)) u_edge (
      .clk      (clk),
      .rst      (rst),
      .level_in (sync_lvl),
      .line_out (line)
   );

   // ==========================================================
   // Per-line decode of requests
   // ==========================================================
   logic [NUM_IN-1:0] req_toggle;
   logic [NUM_IN-1:0] req_lvl_sel;
   logic [NUM_IN-1:0] req_lvl_val;
   logic [NUM_IN-1:0] req_centre;
   logic [NUM_IN-1:0] req_dec;
   logic [NUM_IN-1:0] req_inc;
   logic [NUM_IN-1:0] req_lock;
   logic [NUM_IN-1:0] req_clear;

   for (genvar i = 0; i < NUM_IN; i++) begin : g_dec
      difs_func_t fsel;
      logic       l_toggle;
      logic       l_lvl_sel;
      logic       l_lvl_val;
      logic       l_centre;
      logic       l_dec;
      logic       l_inc;
      logic       l_lock;
      logic       l_clear;

      assign fsel = difs_func_t'(func_sel_ff[FUNC_W*i +: FUNC_W]);

      // All eight codes are legal, so no default arm; a line acts through one arm only
      always_comb begin
         l_toggle  = 1'b0;
         l_lvl_sel = 1'b0;
         l_lvl_val = 1'b0;
         l_centre  = 1'b0;
         l_dec     = 1'b0;
         l_inc     = 1'b0;
         l_lock    = 1'b0;
         l_clear   = 1'b0;
         unique case (fsel)
            FUNC_EDGE_TOGGLE: begin
               l_toggle = line[i].rise;
            end
            FUNC_LEVEL_SELECT_AUTO: begin
               l_lvl_sel = 1'b1;
               l_lvl_val = line[i].level;
            end
            FUNC_CENTRE: begin
               l_centre = line[i].rise;
            end
            FUNC_DEC_LEFT: begin
               l_dec = line[i].level;
            end
            FUNC_INC_RIGHT: begin
               l_inc = line[i].level;
            end
            FUNC_LOCK: begin
               l_lock = line[i].level;
            end
            FUNC_REFERENCE_CLEAR: begin
               l_clear = line[i].rise;
            end
            FUNC_DISABLED: begin
               // Line ignored: every request stays low
            end
         endcase
      end

      assign req_toggle[i]  = l_toggle;
      assign req_lvl_sel[i] = l_lvl_sel;
      assign req_lvl_val[i] = l_lvl_val;
      assign req_centre[i]  = l_centre;
      assign req_dec[i]     = l_dec;
      assign req_inc[i]     = l_inc;
      assign req_lock[i]    = l_lock;
      assign req_clear[i]   = l_clear;
   end

   logic any_toggle;
   logic any_lvl_sel;
   logic any_lvl_val;
   logic any_centre;
   logic any_dec;
   logic any_inc;
   logic any_lock;
   logic any_clear;

   assign any_toggle  = |req_toggle;
   assign any_lvl_sel = |req_lvl_sel;
   assign any_lvl_val = |req_lvl_val;
   assign any_centre  = |req_centre;
   assign any_dec     = |req_dec;
   assign any_inc     = |req_inc;
   assign any_lock    = |req_lock;
   assign any_clear   = |req_clear;

   // ==========================================================
   // Function selection register
   // ==========================================================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         func_sel_ff <= FUNC_SEL_RESET;
      end else if (reg_wr && reg_addr == ADDR_FUNC_SEL) begin
         func_sel_ff <= reg_wdata[SEL_W-1:0];
      end
   end

   // ==========================================================
   // Operation mode
   // ==========================================================
   // Level select outranks toggle: a held level must keep winning
   logic nxt_auto_mode;
   always_comb begin
      nxt_auto_mode = auto_mode_ff;
      if (any_lvl_sel) begin
         nxt_auto_mode = any_lvl_val;
      end else if (any_toggle) begin
         nxt_auto_mode = ~auto_mode_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         auto_mode_ff <= 1'b0;
      end else begin
         auto_mode_ff <= nxt_auto_mode;
      end
   end

   // ==========================================================
   // Reference value
   // ==========================================================
   // Clear wins over steps; steps saturate rather than wrap
   logic [REF_W-1:0] nxt_reference;
   always_comb begin
      nxt_reference = reference_ff;
      if (any_clear) begin
         nxt_reference = REF_RESET;
      end else if (reg_wr && reg_addr == ADDR_REFERENCE) begin
         nxt_reference = reg_wdata[REF_W-1:0];
      end else if (auto_mode_ff && any_dec && !any_inc) begin
         if (reference_ff != '0) begin
            nxt_reference = reference_ff - REF_STEP;
         end
      end else if (auto_mode_ff && any_inc && !any_dec) begin
         if (reference_ff != '1) begin
            nxt_reference = reference_ff + REF_STEP;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reference_ff <= REF_RESET;
      end else begin
         reference_ff <= nxt_reference;
      end
   end

   // ==========================================================
   // Motor drive command
   // ==========================================================
   // Centre run latches until lock, a jog or a software cancel ends it
   logic        centre_run_ff;
   difs_drive_t nxt_drive;
   logic        nxt_centre_run;

   always_comb begin
      nxt_centre_run = centre_run_ff;
      nxt_drive      = DRV_IDLE;
      if (any_centre) begin
         nxt_centre_run = 1'b1;
      end
      if (any_lock) begin
         nxt_drive      = DRV_STOP;
         nxt_centre_run = 1'b0;
      end else if (!auto_mode_ff && any_dec && !any_inc) begin
         nxt_drive      = DRV_LEFT;
         nxt_centre_run = 1'b0;
      end else if (!auto_mode_ff && any_inc && !any_dec) begin
         nxt_drive      = DRV_RIGHT;
         nxt_centre_run = 1'b0;
      end else if (nxt_centre_run) begin
         nxt_drive = DRV_CENTRE;
      end
   end

   // A centre edge in the same cycle outranks the software cancel
   logic centre_cancel;
   assign centre_cancel = reg_wr && reg_addr == ADDR_STATUS && reg_wdata[STAT_AUTO_BIT];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         centre_run_ff <= 1'b0;
      end else if (centre_cancel && !any_centre) begin
         // Software acknowledges the end of a centre run
         centre_run_ff <= 1'b0;
      end else begin
         centre_run_ff <= nxt_centre_run;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drive_cmd_ff <= DRV_IDLE;
      end else begin
         drive_cmd_ff <= nxt_drive;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         centre_start_ff <= 1'b0;
      end else begin
         // Only a fresh run that really reaches the drive pulses
         centre_start_ff <= any_centre & ~centre_run_ff & (nxt_drive == DRV_CENTRE);
      end
   end

   // ==========================================================
   // Register read port
   // ==========================================================
   logic [DATA_W-1:0] nxt_rdata;
   always_comb begin
      nxt_rdata = '0;
      unique case (reg_addr)
         ADDR_FUNC_SEL: begin
            nxt_rdata[SEL_W-1:0] = func_sel_ff;
         end
         ADDR_STATUS: begin
            nxt_rdata[STAT_AUTO_BIT] = auto_mode_ff;
            nxt_rdata[STAT_DRIVE_LSB +: $bits(difs_drive_t)] = drive_cmd_ff;
         end
         ADDR_REFERENCE: begin
            nxt_rdata[REF_W-1:0] = reference_ff;
         end
         ADDR_INPUTS: begin
            nxt_rdata[NUM_IN-1:0] = sync_lvl;
         end
         default: begin
            nxt_rdata = '0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata_ff <= '0;
      end else if (reg_rd) begin
         reg_rdata_ff <= nxt_rdata;
      end else begin
         reg_rdata_ff <= '0;
      end
   end
endmodule // difs_top

// >>> tb/difs_top_props.sv
`timescale 1ns/1ps
module difs_top_props #(
   parameter int NUM_IN = difs_pkg::NUM_INPUTS
) (
   input wire logic                        clk,
   input wire logic                        rst,
   input wire logic [NUM_IN-1:0]           dig_in,
   input wire logic [difs_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [difs_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                        reg_wr,
   input wire logic                        reg_rd,
   input wire logic [difs_pkg::DATA_W-1:0] reg_rdata_ff,
   input wire logic                        auto_mode_ff,
   input wire difs_pkg::difs_drive_t       drive_cmd_ff,
   input wire logic [difs_pkg::REF_W-1:0]  reference_ff,
   input wire logic                        centre_start_ff
);
   import difs_pkg::*;

   // ==========================================================
   // Pin and write history
   // ==========================================================
   // Pin history, wide enough to absorb the sync latency
   logic [NUM_IN-1:0] h_ff [0:4];
   logic              w_ff;
   logic              w2_ff;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 5; i++) h_ff[i] <= '0;
         w_ff  <= 1'b0;
         w2_ff <= 1'b0;
      end else begin
         h_ff[0] <= dig_in;
         for (int i = 1; i < 5; i++) h_ff[i] <= h_ff[i-1];
         w_ff  <= reg_wr;
         w2_ff <= w_ff;
      end
   end
   wire [NUM_IN-1:0] chg = (h_ff[0]^h_ff[1])|(h_ff[1]^h_ff[2])|(h_ff[2]^h_ff[3])|(h_ff[3]^h_ff[4]);
   wire [NUM_IN-1:0] ris = (h_ff[0]&~h_ff[1])|(h_ff[1]&~h_ff[2])|(h_ff[2]&~h_ff[3])|(h_ff[3]&~h_ff[4]);
   wire [NUM_IN-1:0] hi  = h_ff[0]|h_ff[1]|h_ff[2]|h_ff[3]|h_ff[4];
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ==========================================================
   // Properties
   // ==========================================================
   sequence s_centre; centre_start_ff ##1 !centre_start_ff; endsequence
   sequence s_ref_wr; reg_wr && reg_addr == ADDR_REFERENCE; endsequence
   // A select write moves a level-select line's mode two edges later
   property p_mode_cause; $changed(auto_mode_ff) |-> (|chg) || w_ff || w2_ff; endproperty
   property p_centre_cause; $rose(centre_start_ff) |-> |ris; endproperty
   property p_centre_pulse; centre_start_ff |-> drive_cmd_ff == DRV_CENTRE and s_centre; endproperty
   property p_left; drive_cmd_ff == DRV_LEFT |-> (|hi) && (!auto_mode_ff || !$past(auto_mode_ff)); endproperty
   property p_right; drive_cmd_ff == DRV_RIGHT |-> (|hi) && (!auto_mode_ff || !$past(auto_mode_ff)); endproperty
   property p_ref_step;
      $changed(reference_ff) && !w_ff |-> reference_ff == '0
         || reference_ff == $past(reference_ff) + REF_STEP || reference_ff == $past(reference_ff) - REF_STEP;
   endproperty
   property p_ref_auto;
      $changed(reference_ff) && !w_ff && reference_ff != '0 |-> auto_mode_ff || $past(auto_mode_ff);
   endproperty
   property p_ref_wr; s_ref_wr |=> reference_ff == $past(reg_wdata[REF_W-1:0]) || reference_ff == '0; endproperty
   property p_stop; drive_cmd_ff == DRV_STOP |-> |hi; endproperty
   a_mode_cause: assert property (p_mode_cause) else $error("mode changed without cause");
   a_centre_cause: assert property (p_centre_cause) else $error("centre start without edge");
   a_centre_pulse: assert property (p_centre_pulse) else $error("centre start not a pulse");
   a_left: assert property (p_left) else $error("left jog in automatic");
   a_right: assert property (p_right) else $error("right jog in automatic");
   a_ref_step: assert property (p_ref_step) else $error("reference jumped");
   a_ref_auto: assert property (p_ref_auto) else $error("reference stepped in manual");
   a_ref_wr: assert property (p_ref_wr) else $error("reference write lost");
   a_stop: assert property (p_stop) else $error("stop without high line");
endmodule // difs_top_props

bind difs_top difs_top_props #(.NUM_IN(NUM_IN)) u_difs_top_props (.clk(clk), .rst(rst),
   .dig_in(dig_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata_ff(reg_rdata_ff), .auto_mode_ff(auto_mode_ff), .drive_cmd_ff(drive_cmd_ff),
   .reference_ff(reference_ff), .centre_start_ff(centre_start_ff));

// >>> tb/difs_mcs_model.sv
`timescale 1ns/1ps
module difs_mcs_model #(
   parameter int NUM_IN = 4
) (
   input  wire logic              clk,
   input  wire logic [NUM_IN-1:0] want,
   output      logic [NUM_IN-1:0] dig_in
);
   // Push-pull lines: each request lands one edge later, held as a level
   always @(posedge clk) dig_in <= want;
endmodule // difs_mcs_model

// >>> tb/difs_top_tb.sv
`timescale 1ns/1ps
module difs_top_tb;
   import difs_pkg::*;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic [3:0]        want = '0;
   logic [3:0]        dig_in;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata_ff;
   logic              auto_mode_ff;
   difs_drive_t       drive_cmd_ff;
   logic [REF_W-1:0]  reference_ff;
   logic              centre_start_ff;
   int                fails = 0;
   int                total_checks = 0;
   int                pulses = 0;
   initial forever #50 clk = ~clk;
   always @(posedge clk) if (centre_start_ff === 1'b1) pulses++;
   difs_mcs_model u_difs_mcs_model (.clk(clk), .want(want), .dig_in(dig_in));
   difs_top u_difs_top (.clk(clk), .rst(rst), .dig_in(dig_in), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .auto_mode_ff(auto_mode_ff), .drive_cmd_ff(drive_cmd_ff), .reference_ff(reference_ff),
      .centre_start_ff(centre_start_ff));
   // ==========================================================
   // Access tasks
   // ==========================================================
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata_ff, exp);
      // Read data stand for one cycle only
      @(posedge clk);
      #1 chk(reg_rdata_ff, 32'h0000_0000);
   endtask
   task automatic fsel(input difs_func_t c0, c1, c2, c3);
      wr(ADDR_FUNC_SEL, {20'h0, c3, c2, c1, c0});
      rd(ADDR_FUNC_SEL, {20'h0, c3, c2, c1, c0});
   endtask
   // Four edges of hold give five synchronised high cycles
   task automatic pins(input logic [3:0] v, input int n);
      @(posedge clk);
      want <= v;
      repeat (n) @(posedge clk);
   endtask
   task automatic stop_test;
      $display("checks=%0d fails=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end
   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_FUNC_SEL, {20'h0, FUNC_SEL_RESET});
      rd(ADDR_REFERENCE, 32'h0000_0000);
      rd(4'h9, 32'h0000_0000);
      pins(4'h1, 8);
      chk(auto_mode_ff, 32'h1);
      rd(ADDR_STATUS, 32'h0000_0001);
      pins(4'h0, 8);
      chk(auto_mode_ff, 32'h1);
      pins(4'h1, 8);
      chk(auto_mode_ff, 32'h0);
      pins(4'h2, 8);
      chk(pulses, 32'h1);
      chk(drive_cmd_ff, DRV_CENTRE);
      wr(ADDR_STATUS, 32'h0000_0001);
      pins(4'h4, 8);
      chk(drive_cmd_ff, DRV_LEFT);
      pins(4'h8, 8);
      chk(drive_cmd_ff, DRV_RIGHT);
      pins(4'hC, 8);
      chk(drive_cmd_ff, DRV_IDLE);
      pins(4'h1, 8);
      pins(4'h0, 8);
      wr(ADDR_REFERENCE, 32'h0000_0100);
      pins(4'h4, 4);
      pins(4'h0, 8);
      chk(reference_ff, 32'h00FB);
      pins(4'h8, 4);
      pins(4'h0, 8);
      chk(reference_ff, 32'h0100);
      fsel(FUNC_REFERENCE_CLEAR, FUNC_LOCK, FUNC_DEC_LEFT, FUNC_INC_RIGHT);
      pins(4'h1, 8);
      chk(reference_ff, 32'h0000);
      chk(auto_mode_ff, 32'h1);
      pins(4'h2, 8);
      chk(drive_cmd_ff, DRV_STOP);
      pins(4'h0, 8);
      fsel(FUNC_DISABLED, FUNC_DISABLED, FUNC_DISABLED, FUNC_LEVEL_SELECT_AUTO);
      pins(4'h8, 8);
      chk(auto_mode_ff, 32'h1);
      pins(4'h0, 8);
      chk(auto_mode_ff, 32'h0);
      fsel(FUNC_DISABLED, FUNC_DISABLED, FUNC_DISABLED, FUNC_DISABLED);
      wr(ADDR_REFERENCE, 32'h0000_1234);
      pins(4'hF, 8);
      pins(4'h0, 8);
      chk({drive_cmd_ff, auto_mode_ff, reference_ff}, {DRV_IDLE, 1'b0, 16'h1234});
      chk(pulses, 32'h1);
      // A reset in mid-run must restore the defaults over software settings
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_FUNC_SEL, {20'h0, FUNC_SEL_RESET});
      chk({drive_cmd_ff, auto_mode_ff, reference_ff}, 32'h0000_0000);
      stop_test();
   end
endmodule // difs_top_tb
